// File: hw/fpar_pkg.sv
// Shared constants and types for the fan ramp and floor control block
package fpar_pkg;

	// Widths and counts
	localparam int FPAR_NDRV = 3;
	typedef logic [7:0] fpar_byte_t;
	typedef logic [2:0] fpar_rate_t;
	typedef logic [FPAR_NDRV-1:0][7:0] fpar_duty_t;

	// Register map
	localparam fpar_byte_t FPAR_ADDR_ONE = 8'h62;
	localparam fpar_byte_t FPAR_ADDR_TWO = 8'h63;
	localparam fpar_byte_t FPAR_RST_ONE = 8'h00;
	localparam fpar_byte_t FPAR_RST_TWO = 8'h00;
	localparam fpar_byte_t FPAR_RD_IDLE = 8'h00;

	// Field positions in the first register
	localparam int FPAR_ONE_RATE_LSB = 0;
	localparam int FPAR_ONE_EN_BIT = 3;
	localparam int FPAR_ONE_SYNC_BIT = 4;
	localparam int FPAR_ONE_FLOOR_LSB = 5;

	// Field positions in the second register
	localparam int FPAR_TWO_RATE_LSB = 0;
	localparam int FPAR_TWO_EN_BIT = 3;

	// Duty values and ramp pacing
	localparam fpar_byte_t FPAR_DUTY_OFF = 8'h00;
	localparam logic [1:0] FPAR_SLOW_LAST = 2'h3;
	localparam logic [1:0] FPAR_PRE_ZERO = 2'h0;
	localparam logic [1:0] FPAR_PRE_ONE = 2'h1;
	localparam fpar_rate_t FPAR_RATE_NONE = 3'h0;

	// Duty increment per time slot for each ramp code
	function automatic fpar_byte_t fpar_step(input fpar_rate_t rate);
		case (rate)
			3'h0: fpar_step = 8'h01;
			3'h1: fpar_step = 8'h02;
			3'h2: fpar_step = 8'h03;
			3'h3: fpar_step = 8'h04;
			3'h4: fpar_step = 8'h08;
			3'h5: fpar_step = 8'h0C;
			3'h6: fpar_step = 8'h18;
			default: fpar_step = 8'h30;
		endcase
	endfunction

endpackage

// File: hw/fpar_ramp_if.sv
// Interface between the control top and one duty ramp engine
interface fpar_ramp_if;
	logic [7:0] target;
	logic [2:0] rate;
	logic en;
	logic slow;
	logic tick;
	logic [7:0] duty;

	modport ctrl(output target, output rate, output en, output slow, output tick, input duty);
	modport ramp(input target, input rate, input en, input slow, input tick, output duty);
endinterface

// File: hw/fpar_ramp.sv
// Duty ramp engine for one fan drive
module fpar_ramp (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Control side
	fpar_ramp_if.ramp rif
);
	import fpar_pkg::*;

	logic [7:0] duty_reg;
	logic [7:0] duty_next;
	logic [1:0] pre_reg;
	logic [1:0] pre_next;

	// Step size and the clamped candidates in both directions
	wire [7:0] step_w = fpar_step(rif.rate);
	wire [8:0] up_sum = {1'b0, duty_reg} + {1'b0, step_w};
	wire [7:0] up_val = (up_sum >= {1'b0, rif.target}) ? rif.target : up_sum[7:0];
	wire [7:0] dn_gap = duty_reg - rif.target;
	wire [7:0] dn_val = (dn_gap <= step_w) ? rif.target : 8'(duty_reg - step_w);
	wire [7:0] ramp_val = (duty_reg < rif.target) ? up_val : dn_val;
	// Slow mode moves on one slot in four
	wire slow_wait = rif.slow && (pre_reg != FPAR_SLOW_LAST);

	// Next duty; clamping stops overshoot when the target moves mid-ramp
	always_comb begin
		duty_next = duty_reg;
		pre_next = pre_reg;
		if (rif.tick) begin
			if (!rif.en) begin
				duty_next = rif.target;
				pre_next = FPAR_PRE_ZERO;
			end else if (slow_wait) begin
				pre_next = 2'(pre_reg + FPAR_PRE_ONE);
			end else begin
				duty_next = ramp_val;
				pre_next = FPAR_PRE_ZERO;
			end
		end
	end

	// State
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			duty_reg <= FPAR_DUTY_OFF;
			pre_reg <= FPAR_PRE_ZERO;
		end else begin
			duty_reg <= duty_next;
			pre_reg <= pre_next;
		end
	end

	assign rif.duty = duty_reg;

	// Checks on the ramp
	sequence s_rise_slot;
		rif.tick && rif.en && !slow_wait && (duty_reg < rif.target);
	endsequence
	sequence s_fall_slot;
		rif.tick && rif.en && !slow_wait && (duty_reg > rif.target);
	endsequence

	property p_direct;
		@(posedge clk_i) disable iff (!nrst_i)
		rif.tick && !rif.en |=> rif.duty == $past(rif.target);
	endproperty
	a_direct: assert property (p_direct) else $error("unramped drive missed target");

	property p_rise;
		@(posedge clk_i) disable iff (!nrst_i)
		s_rise_slot |=> (rif.duty > $past(duty_reg)) && (rif.duty <= $past(rif.target))
			&& (8'(rif.duty - $past(duty_reg)) <= $past(step_w));
	endproperty
	a_rise: assert property (p_rise) else $error("rising ramp step wrong");

	property p_fall;
		@(posedge clk_i) disable iff (!nrst_i)
		s_fall_slot |=> (rif.duty < $past(duty_reg)) && (rif.duty >= $past(rif.target))
			&& (8'($past(duty_reg) - rif.duty) <= $past(step_w));
	endproperty
	a_fall: assert property (p_fall) else $error("falling ramp step wrong");

	property p_slow_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		rif.tick && rif.en && slow_wait |=> $stable(rif.duty);
	endproperty
	a_slow_hold: assert property (p_slow_hold) else $error("slow ramp moved early");
endmodule

// File: hw/fpar_top.sv
// Fan ramp, floor and tach sync control with its two registers
module fpar_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire fpar_pkg::fpar_byte_t addr_i,
	input wire fpar_pkg::fpar_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output fpar_pkg::fpar_byte_t rdata_o,
	// Global configuration lock
	input wire logic lock_i,
	// Fan control loop, index 0 = drive A, 1 = B, 2 = C
	input wire logic [fpar_pkg::FPAR_NDRV-1:0] auto_mode_i,
	input wire logic [fpar_pkg::FPAR_NDRV-1:0] below_floor_i,
	input wire logic [fpar_pkg::FPAR_NDRV-1:0] slow_ramp_i,
	input wire fpar_pkg::fpar_duty_t calc_duty_i,
	input wire fpar_pkg::fpar_duty_t min_duty_i,
	input wire logic update_tick_i,
	// Duty outputs
	output fpar_pkg::fpar_duty_t duty_o,
	// Speed measurement sync, index 0 = input B, 1 = C, 2 = D
	output logic [fpar_pkg::FPAR_NDRV-1:0] tach_sync_o
);
	import fpar_pkg::*;

	fpar_byte_t one_reg;
	fpar_byte_t one_next;
	fpar_byte_t two_reg;
	fpar_byte_t two_next;
	fpar_byte_t rdata_reg;
	fpar_byte_t rdata_next;
	fpar_byte_t rd_value;
	logic written_reg;

	// Address decode; lock blocks both registers at the write gate
	wire hit_one = (addr_i == FPAR_ADDR_ONE);
	wire hit_two = (addr_i == FPAR_ADDR_TWO);
	wire wr_ok = wr_i && !lock_i;
	wire wr_one = wr_ok && hit_one;
	wire wr_two = wr_ok && hit_two;

	// Register next values
	assign one_next = wr_one ? wdata_i : one_reg;
	assign two_next = wr_two ? wdata_i : two_reg;

	// Read mux; unmapped addresses read as zero
	always_comb begin
		if (hit_one) begin
			rd_value = one_reg;
		end else if (hit_two) begin
			rd_value = two_reg;
		end else begin
			rd_value = FPAR_RD_IDLE;
		end
	end

	// Read data stands only in the cycle after the strobe
	assign rdata_next = rd_i ? rd_value : FPAR_RD_IDLE;

	// Register storage
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			one_reg <= FPAR_RST_ONE;
			two_reg <= FPAR_RST_TWO;
			rdata_reg <= FPAR_RD_IDLE;
		end else begin
			one_reg <= one_next;
			two_reg <= two_next;
			rdata_reg <= rdata_next;
		end
	end

	// Tracks whether software has ever written a register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			written_reg <= 1'b0;
		end else if (wr_one || wr_two) begin
			written_reg <= 1'b1;
		end
	end

	assign rdata_o = rdata_reg;

	// Field extraction
	wire [2:0] rate_a = one_reg[FPAR_ONE_RATE_LSB +: 3];
	wire en_a = one_reg[FPAR_ONE_EN_BIT];
	wire sync_b = one_reg[FPAR_ONE_SYNC_BIT];
	wire [2:0] floor_sel = one_reg[FPAR_ONE_FLOOR_LSB +: 3];
	wire [2:0] rate_c = two_reg[FPAR_TWO_RATE_LSB +: 3];
	wire en_c = two_reg[FPAR_TWO_EN_BIT];

	// Drive B ramp fields sit outside this register pair, so B is not ramped here
	wire [FPAR_NDRV-1:0][2:0] rate_w = {rate_c, FPAR_RATE_NONE, rate_a};
	wire [FPAR_NDRV-1:0] en_w = {en_c, 1'b0, en_a};

	// Speed input B follows the sync bit; C and D always sync to drive C
	assign tach_sync_o = {1'b1, 1'b1, sync_b};

	fpar_duty_t target_w;
	fpar_ramp_if rif [FPAR_NDRV] ();

	// Per-drive floor choice and ramp engine
	genvar g;
	generate
		for (g = 0; g < FPAR_NDRV; g++) begin : g_drv
			wire [7:0] floor_duty = floor_sel[g] ? min_duty_i[g] : FPAR_DUTY_OFF;
			wire below = auto_mode_i[g] && below_floor_i[g];
			assign target_w[g] = below ? floor_duty : calc_duty_i[g];
			assign rif[g].target = target_w[g];
			assign rif[g].rate = rate_w[g];
			assign rif[g].en = en_w[g];
			assign rif[g].slow = slow_ramp_i[g];
			assign rif[g].tick = update_tick_i;
			assign duty_o[g] = rif[g].duty;

			fpar_ramp u_fpar_ramp (
				.clk_i(clk_i),
				.nrst_i(nrst_i),
				.rif(rif[g])
			);
		end
	endgenerate

	// Checks on registers, floors and sync

	sequence s_locked_write;
		wr_i && lock_i;
	endsequence

	property p_lock;
		@(posedge clk_i) disable iff (!nrst_i)
		s_locked_write |=> $stable(one_reg) && $stable(two_reg);
	endproperty
	a_lock: assert property (p_lock) else $error("locked register changed");

	// Write, gap, then read back; a second write in the gap would move the expected value
	sequence s_write_one;
		wr_i && !lock_i && hit_one;
	endsequence
	sequence s_read_back_one;
		!(wr_i && hit_one) ##1 rd_i && hit_one;
	endsequence

	property p_write_one;
		@(posedge clk_i) disable iff (!nrst_i)
		s_write_one ##1 s_read_back_one |=> rdata_o == $past(wdata_i, 3);
	endproperty
	a_write_one: assert property (p_write_one) else $error("first register readback wrong");

	property p_write_two;
		@(posedge clk_i) disable iff (!nrst_i)
		wr_i && !lock_i && (addr_i == FPAR_ADDR_TWO) |=> two_reg == $past(wdata_i);
	endproperty
	a_write_two: assert property (p_write_two) else $error("second register write lost");

	property p_reset_one;
		@(posedge clk_i) disable iff (!nrst_i)
		!written_reg |-> (one_reg == FPAR_RST_ONE) && (tach_sync_o[0] == 1'b0);
	endproperty
	a_reset_one: assert property (p_reset_one) else $error("first register not at reset value");

	property p_reset_two;
		@(posedge clk_i) disable iff (!nrst_i)
		!written_reg |-> two_reg == FPAR_RST_TWO;
	endproperty
	a_reset_two: assert property (p_reset_two) else $error("second register not at reset value");

	property p_sync;
		@(posedge clk_i) disable iff (!nrst_i)
		wr_i && !lock_i && (addr_i == FPAR_ADDR_ONE) |=> tach_sync_o[0] == $past(wdata_i[FPAR_ONE_SYNC_BIT]);
	endproperty
	a_sync: assert property (p_sync) else $error("speed input B sync wrong");

	property p_sync_cd;
		@(posedge clk_i) disable iff (!nrst_i)
		!tach_sync_o[0] |-> tach_sync_o[2:1] == 2'b11;
	endproperty
	a_sync_cd: assert property (p_sync_cd) else $error("speed inputs C and D not synced");

	property p_floor_a;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && auto_mode_i[0] && below_floor_i[0] && !en_a
			|=> duty_o[0] == ($past(floor_sel[0]) ? $past(min_duty_i[0]) : FPAR_DUTY_OFF);
	endproperty
	a_floor_a: assert property (p_floor_a) else $error("drive A floor duty wrong");

	property p_floor_b;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && auto_mode_i[1] && below_floor_i[1]
			|=> duty_o[1] == ($past(floor_sel[1]) ? $past(min_duty_i[1]) : FPAR_DUTY_OFF);
	endproperty
	a_floor_b: assert property (p_floor_b) else $error("drive B floor duty wrong");

	property p_floor_c;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && auto_mode_i[2] && below_floor_i[2] && !en_c
			|=> duty_o[2] == ($past(floor_sel[2]) ? $past(min_duty_i[2]) : FPAR_DUTY_OFF);
	endproperty
	a_floor_c: assert property (p_floor_c) else $error("drive C floor duty wrong");

	property p_read_idle;
		@(posedge clk_i) disable iff (!nrst_i)
		!rd_i |=> rdata_o == FPAR_RD_IDLE;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");

	property p_unramped_a;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && !en_a |=> duty_o[0] == $past(target_w[0]);
	endproperty
	a_unramped_a: assert property (p_unramped_a) else $error("drive A not applied directly");

	property p_rate_c;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && en_c && !slow_ramp_i[2] && (duty_o[2] < target_w[2])
			|=> 8'(duty_o[2] - $past(duty_o[2])) <= fpar_step($past(rate_c));
	endproperty
	a_rate_c: assert property (p_rate_c) else $error("drive C ramp rate ignored");

	property p_ramp_a_moves;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && en_a && !slow_ramp_i[0] && (duty_o[0] != target_w[0])
			|=> duty_o[0] != $past(duty_o[0]);
	endproperty
	a_ramp_a_moves: assert property (p_ramp_a_moves) else $error("drive A ramp stalled");

	property p_no_tick_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		!update_tick_i |=> $stable(duty_o);
	endproperty
	a_no_tick_hold: assert property (p_no_tick_hold) else $error("duty moved without update slot");

	// Readback paths for both registers
	property p_read_one;
		@(posedge clk_i) disable iff (!nrst_i)
		rd_i && hit_one |=> rdata_o == $past(one_reg);
	endproperty
	a_read_one: assert property (p_read_one) else $error("first register read data wrong");

	property p_read_two;
		@(posedge clk_i) disable iff (!nrst_i)
		rd_i && hit_two |=> rdata_o == $past(two_reg);
	endproperty
	a_read_two: assert property (p_read_two) else $error("second register read data wrong");

	// Registers move only through an accepted write
	property p_hold_one;
		@(posedge clk_i) disable iff (!nrst_i)
		!(wr_i && !lock_i && hit_one) |=> $stable(one_reg);
	endproperty
	a_hold_one: assert property (p_hold_one) else $error("first register changed without write");

	property p_hold_two;
		@(posedge clk_i) disable iff (!nrst_i)
		!(wr_i && !lock_i && hit_two) |=> $stable(two_reg);
	endproperty
	a_hold_two: assert property (p_hold_two) else $error("second register changed without write");

	property p_sync_stable;
		@(posedge clk_i) disable iff (!nrst_i)
		!(wr_i && !lock_i && hit_one) |=> $stable(tach_sync_o);
	endproperty
	a_sync_stable: assert property (p_sync_stable) else $error("speed sync moved without write");

	// Drive B has no ramp fields here, so it always lands on its target
	property p_drive_b_direct;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i |=> duty_o[1] == $past(target_w[1]);
	endproperty
	a_drive_b_direct: assert property (p_drive_b_direct) else $error("drive B missed its target");

	// Outside the floor band an unramped drive follows the computed duty
	property p_calc_a;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && !(auto_mode_i[0] && below_floor_i[0]) && !en_a
			|=> duty_o[0] == $past(calc_duty_i[0]);
	endproperty
	a_calc_a: assert property (p_calc_a) else $error("drive A ignored computed duty");

	property p_unramped_c;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && !en_c |=> duty_o[2] == $past(target_w[2]);
	endproperty
	a_unramped_c: assert property (p_unramped_c) else $error("drive C not applied directly");

	property p_fall_c;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && en_c && !slow_ramp_i[2] && (duty_o[2] > target_w[2])
			|=> (duty_o[2] >= $past(target_w[2])) && (8'($past(duty_o[2]) - duty_o[2]) <= fpar_step($past(rate_c)));
	endproperty
	a_fall_c: assert property (p_fall_c) else $error("drive C falling step wrong");

	property p_clamp_a;
		@(posedge clk_i) disable iff (!nrst_i)
		update_tick_i && en_a && (duty_o[0] < target_w[0])
			|=> duty_o[0] <= $past(target_w[0]);
	endproperty
	a_clamp_a: assert property (p_clamp_a) else $error("drive A overshot its target");
endmodule

// File: dv/fpar_fan_model.sv
// Behavioural fan load that counts speed changes on drive A
module fpar_fan_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Drive levels from the block
	input wire fpar_pkg::fpar_duty_t duty_i,
	// Observed speed changes
	output int moves_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import fpar_pkg::*;
	fpar_byte_t last_reg;
	// A fan hears every step, so count each change of drive A
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			last_reg <= FPAR_DUTY_OFF;
			moves_o <= 0;
		end else if (duty_i[0] !== last_reg) begin
			last_reg <= duty_i[0];
			moves_o <= moves_o + 1;
		end
	end
endmodule

// File: dv/tb_fan_pwm_acoustic_ramp_control.sv
// Self-checking bench for the fan ramp and floor control block
module tb_fan_pwm_acoustic_ramp_control;
	timeunit 1ns;
	timeprecision 1ps;
	import fpar_pkg::*;
	logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, lock_i = 0, update_tick_i = 0;
	fpar_byte_t addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rv;
	logic [2:0] auto_mode_i = 3'h0, below_floor_i = 3'h0, slow_ramp_i = 3'h0, tach_sync_o;
	fpar_duty_t calc_duty_i = '0, min_duty_i = '0, duty_o;
	int fails = 0, samples_checked = 0, moves, m;
	fpar_byte_t step_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};

	// Block under test and its fan load
	fpar_top u_fpar_top (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lock_i(lock_i), .auto_mode_i(auto_mode_i),
		.below_floor_i(below_floor_i), .slow_ramp_i(slow_ramp_i), .calc_duty_i(calc_duty_i),
		.min_duty_i(min_duty_i), .update_tick_i(update_tick_i), .duty_o(duty_o), .tach_sync_o(tach_sync_o));
	fpar_fan_model u_fpar_fan_model (.clk_i(clk_i), .nrst_i(nrst_i), .duty_i(duty_o), .moves_o(moves));

	// 125 MHz clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// Compare tasks, one per kind of result
	task automatic check_byte(input fpar_byte_t got, input fpar_byte_t exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic check_duty(input fpar_duty_t exp);
		samples_checked++;
		if (duty_o !== exp) begin
			fails++;
			$display("wrong value at %0t: duty got %h want %h", $time, duty_o, exp);
		end
	endtask
	task automatic check_sync(input logic [2:0] exp);
		samples_checked++;
		if (tach_sync_o !== exp) begin
			fails++;
			$display("wrong value at %0t: sync got %b want %b", $time, tach_sync_o, exp);
		end
	endtask

	// Register bus cycles; a write is live one edge later
	task automatic wr_reg(input fpar_byte_t a, input fpar_byte_t d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input fpar_byte_t a, output fpar_byte_t d);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// New computed duty plus one time slot
	task automatic tick_to(input fpar_duty_t d);
		@(posedge clk_i);
		calc_duty_i <= d;
		update_tick_i <= 1'b1;
		@(posedge clk_i);
		update_tick_i <= 1'b0;
		#1;
	endtask

	task automatic t_reset;
		rd_reg(FPAR_ADDR_ONE, rv);
		check_byte(rv, 8'h00, "reg one");
		rd_reg(FPAR_ADDR_TWO, rv);
		check_byte(rv, 8'h00, "reg two");
		check_duty('0);
		check_sync(3'b110);
		$display("test reset done");
	endtask
	task automatic t_sync;
		wr_reg(FPAR_ADDR_ONE, 8'h10);
		check_sync(3'b111);
		rd_reg(FPAR_ADDR_ONE, rv);
		check_byte(rv, 8'h10, "reg one back");
		wr_reg(FPAR_ADDR_ONE, 8'h00);
		check_sync(3'b110);
		rd_reg(8'h64, rv);
		check_byte(rv, 8'h00, "unmapped");
		$display("test sync done");
	endtask
	// Every ramp code from zero, then the clamp at the target
	task automatic t_rates;
		for (int c = 0; c < 8; c++) begin
			wr_reg(FPAR_ADDR_ONE, 8'h00);
			tick_to('0);
			wr_reg(FPAR_ADDR_ONE, 8'h08 | 8'(c));
			tick_to({8'h00, 8'h00, 8'hc8});
			check_duty({8'h00, 8'h00, step_tab[c]});
		end
		wr_reg(FPAR_ADDR_ONE, 8'h00);
		tick_to('0);
		wr_reg(FPAR_ADDR_ONE, 8'h0b);
		tick_to({8'h00, 8'h00, 8'h0a});
		check_duty({8'h00, 8'h00, 8'h04});
		tick_to({8'h00, 8'h00, 8'h0a});
		check_duty({8'h00, 8'h00, 8'h08});
		tick_to({8'h00, 8'h00, 8'h0a});
		check_duty({8'h00, 8'h00, 8'h0a});
		wr_reg(FPAR_ADDR_ONE, 8'h00);
		tick_to({8'h00, 8'h77, 8'h90});
		check_duty({8'h00, 8'h77, 8'h90});
		$display("test rates done");
	endtask
	// Slow mode holds three slots and moves on the fourth
	task automatic t_slow;
		tick_to('0);
		@(posedge clk_i);
		slow_ramp_i <= 3'h1;
		wr_reg(FPAR_ADDR_ONE, 8'h0a);
		m = moves;
		repeat (3) tick_to({8'h00, 8'h00, 8'h64});
		check_duty('0);
		tick_to({8'h00, 8'h00, 8'h64});
		check_duty({8'h00, 8'h00, 8'h03});
		// Fan load registers the new duty one edge later
		@(posedge clk_i);
		#1;
		check_byte(8'(moves - m), 8'h01, "fan moves");
		@(posedge clk_i);
		slow_ramp_i <= 3'h0;
		wr_reg(FPAR_ADDR_ONE, 8'h00);
		$display("test slow done");
	endtask
	// Floor choice per drive below the start threshold
	task automatic t_floor;
		@(posedge clk_i);
		min_duty_i <= {8'h1e, 8'h14, 8'h0a};
		auto_mode_i <= 3'h7;
		below_floor_i <= 3'h7;
		tick_to({8'h32, 8'h32, 8'h32});
		check_duty('0);
		wr_reg(FPAR_ADDR_ONE, 8'ha0);
		tick_to({8'h32, 8'h32, 8'h32});
		check_duty({8'h1e, 8'h00, 8'h0a});
		wr_reg(FPAR_ADDR_ONE, 8'h40);
		tick_to({8'h32, 8'h32, 8'h32});
		check_duty({8'h00, 8'h14, 8'h00});
		@(posedge clk_i);
		below_floor_i <= 3'h0;
		tick_to({8'h32, 8'h32, 8'h32});
		check_duty({8'h32, 8'h32, 8'h32});
		@(posedge clk_i);
		auto_mode_i <= 3'h0;
		wr_reg(FPAR_ADDR_ONE, 8'h00);
		$display("test floor done");
	endtask
	task automatic t_drive_c;
		tick_to('0);
		wr_reg(FPAR_ADDR_TWO, 8'h0d);
		tick_to({8'h64, 8'h00, 8'h64});
		check_duty({8'h0c, 8'h00, 8'h64});
		tick_to({8'h04, 8'h00, 8'h64});
		check_duty({8'h04, 8'h00, 8'h64});
		wr_reg(FPAR_ADDR_TWO, 8'h00);
		$display("test drive c done");
	endtask
	task automatic t_lock;
		wr_reg(FPAR_ADDR_ONE, 8'h15);
		wr_reg(FPAR_ADDR_TWO, 8'h06);
		@(posedge clk_i);
		lock_i <= 1'b1;
		wr_reg(FPAR_ADDR_ONE, 8'hff);
		wr_reg(FPAR_ADDR_TWO, 8'h01);
		rd_reg(FPAR_ADDR_ONE, rv);
		check_byte(rv, 8'h15, "locked one");
		rd_reg(FPAR_ADDR_TWO, rv);
		check_byte(rv, 8'h06, "locked two");
		$display("test lock done");
	endtask

	// Single place where the run ends
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard at 20000 cycles, far above the run length
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_sync();
		t_rates();
		t_slow();
		t_floor();
		t_drive_c();
		t_lock();
		give_verdict();
	end
endmodule
